// ---- rtl/oag_top.sv ----
// operand address generator: working registers, two address units, literal decode
`timescale 1ns/100ps
// Notes on behaviour
// - file-register direct takes the address straight from the instruction field
// - register direct uses the named working register, no memory address
// - register indirect uses the base pointer value as address
// - post-modified uses old pointer, then steps and writes pointer back
// - pre-modified steps the pointer by a signed constant, uses new value
// - indexed address is base pointer plus offset register
// - literal-offset address is base pointer plus instruction literal
// - data-transfer instructions may also use indexed mode
// - transfer source and destination modes independent, one shared offset field
// - jump literal is 16-bit signed, sign-extended to the target
// - interrupt-hold literal is a 14-bit unsigned count
// - some instructions take operands implied by the opcode
// - no-operation has no operands and causes no access
// - hold blocks interrupts below priority 7 for the counted instructions
module oag_top (
	input  wire logic                     sys_clk,
	input  wire logic                     reset,
	input  wire logic                     req_valid,
	input  wire oag_pkg::oag_kind_e       req_kind,
	input  wire logic                     req_byte,
	input  wire oag_pkg::oag_mode_e       src_mode,
	input  wire logic [3:0]               src_reg,
	input  wire oag_pkg::oag_mode_e       dst_mode,
	input  wire logic [3:0]               dst_reg,
	input  wire logic [3:0]               off_reg,
	input  wire logic [15:0]              req_lit,
	input  wire logic [15:0]              req_file_addr,
	input  wire logic                     wb_en,
	input  wire logic [3:0]               wb_idx,
	input  wire logic [15:0]              wb_data,
	output logic                          out_valid_r,
	output logic [15:0]                   src_ea_r,
	output logic [15:0]                   dst_ea_r,
	output logic                          src_mem_en_r,
	output logic                          dst_mem_en_r,
	output logic                          src_reg_en_r,
	output logic                          dst_reg_en_r,
	output logic [3:0]                    src_reg_idx_r,
	output logic [3:0]                    dst_reg_idx_r,
	output logic [15:0]                   src_reg_data_r,
	output logic                          mode_err_r,
	output logic                          jump_valid_r,
	output logic [oag_pkg::PC_W-1:0]      jump_target_r,
	output logic [13:0]                   hold_count_r,
	output logic                          irq_hold_r,
	output logic [2:0]                    irq_hold_prio_r
);
	import oag_pkg::*;
	// ==========================================================
	// working register file
	logic [DATA_W-1:0]     regs_r [REG_N];
	oag_ea_if              src_if ();
	oag_ea_if              dst_if ();
	// ==========================================================
	// instruction class decode
	wire                   k_xfer    = (req_kind == OAG_K_TRANSFER);
	wire                   k_norm    = (req_kind == OAG_K_NORMAL);
	wire                   k_jump    = (req_kind == OAG_K_JUMP);
	wire                   k_hold    = (req_kind == OAG_K_HOLD);
	wire                   k_impl    = (req_kind == OAG_K_IMPLIED);
	wire                   has_ops   = k_xfer || k_norm || k_impl;
	// indexed is only legal for transfers; ordinary instructions lose that operand
	wire                   src_bad   = k_norm && (src_mode == OAG_M_INDEX);
	wire                   dst_bad   = k_norm && (dst_mode == OAG_M_INDEX);
	wire                   mode_err  = req_valid && (src_bad || dst_bad);
	// a dropped operand is forced to none, so its unit never forms an access
	wire                   src_off   = !has_ops || src_bad;
	wire                   dst_off   = !has_ops || dst_bad;
	// implied classes operate on a fixed register chosen by the opcode
	wire oag_mode_e        src_m     = oag_mode_e'(src_off ? OAG_M_NONE :
		(k_impl ? OAG_M_REG : src_mode));
	wire oag_mode_e        dst_m     = oag_mode_e'(dst_off ? OAG_M_NONE :
		(k_impl ? OAG_M_REG : dst_mode));
	wire [REG_IDX_W-1:0]   src_idx   = k_impl ? IMPLIED_REG : src_reg;
	wire [REG_IDX_W-1:0]   dst_idx   = k_impl ? IMPLIED_REG : dst_reg;
	// ==========================================================
	// shared operand inputs
	wire [DATA_W-1:0]      step      = req_byte ? STEP_BYTE : STEP_WORD;
	// one offset field feeds both units, so both indexed sums use one value
	wire [DATA_W-1:0]      off_val   = regs_r[off_reg];
	wire [DATA_W-1:0]      lit_off   = {{(DATA_W-LIT_OFF_W){req_lit[LIT_OFF_W-1]}},
		req_lit[LIT_OFF_W-1:0]};
	wire [PC_W-1:0]        jump_ext  = {{(PC_W-JUMP_LIT_W){req_lit[JUMP_LIT_W-1]}},
		req_lit};
	wire [HOLD_LIT_W-1:0]  hold_lit  = req_lit[HOLD_LIT_W-1:0];
	assign src_if.mode      = src_m;
	// base values read once, shared by the units and the data output
	wire [DATA_W-1:0]      src_base  = regs_r[src_idx];
	wire [DATA_W-1:0]      dst_base  = regs_r[dst_idx];
	assign src_if.base      = src_base;
	assign src_if.offset    = off_val;
	assign src_if.lit       = lit_off;
	assign src_if.step      = step;
	assign src_if.file_addr = req_file_addr;
	assign dst_if.mode      = dst_m;
	assign dst_if.base      = dst_base;
	assign dst_if.offset    = off_val;
	assign dst_if.lit       = lit_off;
	assign dst_if.step      = step;
	assign dst_if.file_addr = req_file_addr;
	// ==========================================================
	// address units
	oag_ea_unit u_src (
		.op (src_if)
	);
	oag_ea_unit u_dst (
		.op (dst_if)
	);
	// ==========================================================
	// interrupt hold counter
	// counts accepted requests after the hold itself; a new hold reloads it
	wire                   hold_take = req_valid && k_hold;
	wire                   hold_live = (hold_count_r != HOLD_ZERO);
	wire                   hold_tick = req_valid && !k_hold && hold_live;
	wire [HOLD_LIT_W-1:0]  hold_dec  = HOLD_LIT_W'(hold_count_r - 14'h0001);
	// a hold landing while another runs simply restarts the count
	wire [HOLD_LIT_W-1:0]  hold_nxt  = hold_take ? hold_lit :
		(hold_tick ? hold_dec : hold_count_r);
	wire                   irq_hold_nxt = (hold_nxt != HOLD_ZERO);
	// ==========================================================
	// next values of the one-cycle flags
	// gating with req_valid keeps idle cycles from starting an access
	wire                   src_mem_en_nxt = req_valid && src_if.mem_en;
	wire                   dst_mem_en_nxt = req_valid && dst_if.mem_en;
	wire                   src_reg_en_nxt = req_valid && src_if.reg_en;
	wire                   dst_reg_en_nxt = req_valid && dst_if.reg_en;
	wire                   jump_valid_nxt = req_valid && k_jump;
	// ==========================================================
	// pointer writeback enables
	wire                   src_upd   = req_valid && src_if.ptr_we;
	wire                   dst_upd   = req_valid && dst_if.ptr_we;
	// ==========================================================
	// register file update
	// pointer writes win over an external write to the same register;
	// destination wins over source when both step one pointer
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			for (int i = 0; i < REG_N; i++) begin
				regs_r[i] <= REG_RESET;
			end
		end else begin
			if (wb_en) begin
				regs_r[wb_idx] <= wb_data;
			end
			if (src_upd) begin
				regs_r[src_idx] <= src_if.new_ptr;
			end
			if (dst_upd) begin
				regs_r[dst_idx] <= dst_if.new_ptr;
			end
		end
	end
	// ==========================================================
	// operand flags, one-cycle pulses
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			out_valid_r  <= 1'b0;
			src_mem_en_r <= 1'b0;
			dst_mem_en_r <= 1'b0;
			src_reg_en_r <= 1'b0;
			dst_reg_en_r <= 1'b0;
			mode_err_r   <= 1'b0;
		end else begin
			out_valid_r  <= req_valid;
			src_mem_en_r <= src_mem_en_nxt;
			dst_mem_en_r <= dst_mem_en_nxt;
			src_reg_en_r <= src_reg_en_nxt;
			dst_reg_en_r <= dst_reg_en_nxt;
			mode_err_r   <= mode_err;
		end
	end
	// ==========================================================
	// operand addresses and register data
	// these follow the inputs every cycle; only out_valid_r gives them meaning
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			src_ea_r       <= 16'h0000;
			dst_ea_r       <= 16'h0000;
			src_reg_idx_r  <= 4'h0;
			dst_reg_idx_r  <= 4'h0;
			src_reg_data_r <= 16'h0000;
		end else begin
			src_ea_r       <= src_if.ea;
			dst_ea_r       <= dst_if.ea;
			src_reg_idx_r  <= src_idx;
			dst_reg_idx_r  <= dst_idx;
			src_reg_data_r <= src_base;
		end
	end
	// ==========================================================
	// jump target
	// the target is held between jumps so a late consumer still sees it
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			jump_valid_r  <= 1'b0;
			jump_target_r <= '0;
		end else begin
			jump_valid_r  <= jump_valid_nxt;
			if (jump_valid_nxt) begin
				jump_target_r <= jump_ext;
			end
		end
	end
	// ==========================================================
	// interrupt hold outputs
	// the level is fixed; only irq_hold_r says whether it applies
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			hold_count_r    <= HOLD_ZERO;
			irq_hold_r      <= 1'b0;
			irq_hold_prio_r <= 3'h0;
		end else begin
			hold_count_r    <= hold_nxt;
			irq_hold_r      <= irq_hold_nxt;
			irq_hold_prio_r <= HOLD_PRIO;
		end
	end
endmodule

// ---- inc/oag_pkg.sv ----
// constants, enumerations and field widths for the operand address generator
package oag_pkg;
	// ==========================================================
	// widths
	localparam int DATA_W      = 16;
	localparam int REG_N       = 16;
	localparam int REG_IDX_W   = 4;
	localparam int OFF_FIELD_W = 4;
	localparam int JUMP_LIT_W  = 16;
	localparam int HOLD_LIT_W  = 14;
	localparam int LIT_OFF_W   = 10;
	localparam int PC_W        = 24;
	// ==========================================================
	// values
	localparam logic [DATA_W-1:0]    STEP_BYTE   = 16'h0001;
	localparam logic [DATA_W-1:0]    STEP_WORD   = 16'h0002;
	localparam logic [DATA_W-1:0]    REG_RESET   = 16'h0000;
	localparam logic [2:0]           HOLD_PRIO   = 3'h7;
	localparam logic [REG_IDX_W-1:0] IMPLIED_REG = 4'h0;
	localparam logic [HOLD_LIT_W-1:0] HOLD_ZERO  = 14'h0000;
	// ==========================================================
	// operand addressing modes
	typedef enum logic [9:0] {
		OAG_M_NONE     = 10'h001,
		OAG_M_FILE     = 10'h002,
		OAG_M_REG      = 10'h004,
		OAG_M_IND      = 10'h008,
		OAG_M_POST_INC = 10'h010,
		OAG_M_POST_DEC = 10'h020,
		OAG_M_PRE_INC  = 10'h040,
		OAG_M_PRE_DEC  = 10'h080,
		OAG_M_INDEX    = 10'h100,
		OAG_M_LIT      = 10'h200
	} oag_mode_e;
	// ==========================================================
	// instruction classes
	typedef enum logic [5:0] {
		OAG_K_NORMAL   = 6'h01,
		OAG_K_TRANSFER = 6'h02,
		OAG_K_JUMP     = 6'h04,
		OAG_K_HOLD     = 6'h08,
		OAG_K_NOP      = 6'h10,
		OAG_K_IMPLIED  = 6'h20
	} oag_kind_e;
endpackage

// ---- inc/oag_ea_if.sv ----
// operand request and result bundle between the top and one address unit
`timescale 1ns/100ps
interface oag_ea_if;
	import oag_pkg::*;
	oag_mode_e         mode;
	logic [DATA_W-1:0] base;
	logic [DATA_W-1:0] offset;
	logic [DATA_W-1:0] lit;
	logic [DATA_W-1:0] step;
	logic [DATA_W-1:0] file_addr;
	logic [DATA_W-1:0] ea;
	logic [DATA_W-1:0] new_ptr;
	logic              ptr_we;
	logic              mem_en;
	logic              reg_en;
	modport top  (output mode, base, offset, lit, step, file_addr,
		input ea, new_ptr, ptr_we, mem_en, reg_en);
	modport unit (input mode, base, offset, lit, step, file_addr,
		output ea, new_ptr, ptr_we, mem_en, reg_en);
endinterface

// ---- rtl/oag_ea_unit.sv ----
// effective address for one operand, purely combinational
`timescale 1ns/100ps
module oag_ea_unit (
	oag_ea_if.unit op
);
	import oag_pkg::*;
	// ==========================================================
	// mode decode
	wire               is_file = (op.mode == OAG_M_FILE);
	wire               is_reg  = (op.mode == OAG_M_REG);
	wire               is_none = (op.mode == OAG_M_NONE);
	wire               is_pre  = (op.mode == OAG_M_PRE_INC) || (op.mode == OAG_M_PRE_DEC);
	wire               is_post = (op.mode == OAG_M_POST_INC) || (op.mode == OAG_M_POST_DEC);
	wire               is_dec  = (op.mode == OAG_M_PRE_DEC) || (op.mode == OAG_M_POST_DEC);
	wire               is_idx  = (op.mode == OAG_M_INDEX);
	wire               is_lit  = (op.mode == OAG_M_LIT);
	// decrement is the two's complement of the step, so one adder serves both
	wire [DATA_W-1:0]  step_s  = is_dec ? DATA_W'(~op.step + 16'h0001) : op.step;
	wire [DATA_W-1:0]  moved   = DATA_W'(op.base + step_s);
	// ==========================================================
	// address selection
	assign op.ea      = is_file ? op.file_addr :
		is_pre ? moved :
		is_idx ? DATA_W'(op.base + op.offset) :
		is_lit ? DATA_W'(op.base + op.lit) :
		op.base;
	assign op.new_ptr = moved;
	assign op.ptr_we  = is_pre || is_post;
	assign op.mem_en  = !(is_reg || is_none);
	assign op.reg_en  = is_reg;
endmodule

// ---- verif/oag_top_monitor.sv ----
// concurrent checks on the ports of the operand address generator
`timescale 1ns/100ps
module oag_top_monitor (
	input logic                     sys_clk,
	input logic                     reset,
	input logic                     req_valid,
	input oag_pkg::oag_kind_e       req_kind,
	input oag_pkg::oag_mode_e       src_mode,
	input logic [15:0]              req_lit,
	input logic [15:0]              req_file_addr,
	input logic [15:0]              src_ea_r,
	input logic                     src_mem_en_r,
	input logic                     src_reg_en_r,
	input logic [3:0]               src_reg_idx_r,
	input logic                     mode_err_r,
	input logic [oag_pkg::PC_W-1:0] jump_target_r,
	input logic [13:0]              hold_count_r,
	input logic                     irq_hold_r,
	input logic [2:0]               irq_hold_prio_r
);
	import oag_pkg::*;
	// ==========================================================
	// properties, all on the core clock
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire ops = req_valid && (req_kind == OAG_K_NORMAL || req_kind == OAG_K_TRANSFER);
	file_addr_a: assert property (ops && src_mode == OAG_M_FILE |=> src_mem_en_r &&
		src_ea_r == $past(req_file_addr)) else $error("file address not taken");
	reg_direct_a: assert property (ops && src_mode == OAG_M_REG
		|=> src_reg_en_r && !src_mem_en_r) else $error("register direct made an access");
	index_refuse_a: assert property (req_valid && req_kind == OAG_K_NORMAL &&
		src_mode == OAG_M_INDEX |=> mode_err_r && !src_mem_en_r) else $error("indexed on ordinary op");
	jump_sext_a: assert property (req_valid && req_kind == OAG_K_JUMP |=>
		jump_target_r == {{8{jump_target_r[15]}}, $past(req_lit)}) else $error("jump literal");
	hold_load_a: assert property (req_valid && req_kind == OAG_K_HOLD |=>
		{2'b00, hold_count_r} == ($past(req_lit) & 16'h3fff)) else $error("hold count load");
	hold_step_a: assert property (irq_hold_r && req_valid && req_kind != OAG_K_HOLD |=>
		hold_count_r == $past(hold_count_r) - 14'h0001) else $error("hold count step");
	hold_prio_a: assert property (irq_hold_r |-> irq_hold_prio_r == HOLD_PRIO
		&& hold_count_r != HOLD_ZERO) else $error("hold level or priority");
	nop_quiet_a: assert property (req_valid && req_kind == OAG_K_NOP
		|=> !src_mem_en_r && !src_reg_en_r) else $error("no-operation made an access");
	implied_reg_a: assert property (req_valid && req_kind == OAG_K_IMPLIED
		|=> src_reg_en_r && src_reg_idx_r == IMPLIED_REG) else $error("implied operand");
	cover property (ops && src_mode == OAG_M_INDEX);
	cover property (irq_hold_r ##1 !irq_hold_r);
	cover property (req_valid && req_kind == OAG_K_JUMP);
endmodule
bind oag_top oag_top_monitor u_oag_top_monitor (.*);

// ---- verif/oag_reg_loader.sv ----
// partner model: preloads working registers through the write port
`timescale 1ns/100ps
module oag_reg_loader (
	input  logic        sys_clk,
	output logic        wb_en = 1'b0,
	output logic [3:0]  wb_idx = 4'h0,
	output logic [15:0] wb_data = 16'h0000
);
	// one write per call; afterwards data shows the inverse so a stale value never passes
	task automatic load(input logic [3:0] idx, input logic [15:0] val);
		@(posedge sys_clk);
		#1;
		{wb_en, wb_idx, wb_data} = {1'b1, idx, val};
		@(posedge sys_clk);
		#1;
		{wb_en, wb_data} = {1'b0, ~val};
	endtask
endmodule

// ---- verif/tb_oag_top.sv ----
// self-checking bench for the operand address generator
`timescale 1ns/100ps
module tb_oag_top;
	import oag_pkg::*;
	// ==========================================================
	// signals, clock and timeout
	logic        sys_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_byte = 1'b0;
	oag_kind_e   req_kind = OAG_K_NOP;
	oag_mode_e   src_mode = OAG_M_NONE, dst_mode = OAG_M_NONE;
	logic [3:0]  src_reg = 4'h0, dst_reg = 4'h0, off_reg = 4'h0, wb_idx;
	logic [15:0] req_lit = 16'h0000, req_file_addr = 16'h0000, wb_data;
	logic [15:0] src_ea_r, dst_ea_r, src_reg_data_r;
	logic [3:0]  src_reg_idx_r, dst_reg_idx_r;
	logic        wb_en, out_valid_r, src_mem_en_r, dst_mem_en_r, src_reg_en_r, dst_reg_en_r;
	logic        mode_err_r, jump_valid_r, irq_hold_r;
	logic [23:0] jump_target_r;
	logic [13:0] hold_count_r;
	logic [2:0]  irq_hold_prio_r;
	int          num_errors = 0, n_compared = 0, cycles = 0;
	oag_top        u_oag_top (.*);
	oag_reg_loader u_oag_reg_loader (.*);
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	// ceiling far above the thirty or so cycles the scenarios need
	always @(posedge sys_clk)
		if (++cycles == 1000) begin
			num_errors++;
			test_done();
		end
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// request driven just after an edge; on return its registered answer is visible
	task automatic rq(input oag_kind_e k, input oag_mode_e sm, input logic [3:0] sr,
			input oag_mode_e dm, input logic [3:0] dr, input logic [15:0] lit);
		req_valid = 1'b1;
		req_kind  = k;
		src_mode  = sm;
		src_reg   = sr;
		dst_mode  = dm;
		dst_reg   = dr;
		req_lit   = lit;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic t_ptr();
		u_oag_reg_loader.load(4'h1, 16'h0100);
		u_oag_reg_loader.load(4'h2, 16'h0200);
		rq(OAG_K_TRANSFER, OAG_M_IND, 4'h1, OAG_M_POST_INC, 4'h2, 16'h0000);
		chk("ind post", {src_ea_r, dst_ea_r}, 32'h0100_0200);
		chk("valid data", {out_valid_r, src_reg_data_r}, 17'h10100);
		req_byte = 1'b1;
		rq(OAG_K_TRANSFER, OAG_M_PRE_DEC, 4'h2, OAG_M_POST_DEC, 4'h1, 16'h0000);
		chk("pre byte", {src_ea_r, dst_ea_r}, 32'h0201_0100);
		chk("pre data", src_reg_data_r, 16'h0202);
		req_byte = 1'b0;
		rq(OAG_K_TRANSFER, OAG_M_PRE_INC, 4'h1, OAG_M_IND, 4'h2, 16'h0000);
		chk("pre word", {src_ea_r, dst_ea_r}, 32'h0101_0201);
		req_valid = 1'b0;
	endtask
	task automatic t_offset();
		u_oag_reg_loader.load(4'h4, 16'h0400);
		u_oag_reg_loader.load(4'h6, 16'h0010);
		off_reg = 4'h6;
		rq(OAG_K_TRANSFER, OAG_M_INDEX, 4'h4, OAG_M_INDEX, 4'h6, 16'h0000);
		chk("index", {src_ea_r, dst_ea_r}, 32'h0410_0020);
		rq(OAG_K_TRANSFER, OAG_M_LIT, 4'h4, OAG_M_LIT, 4'h6, 16'hfff0);
		chk("literal", {src_ea_r, dst_ea_r}, 32'h03f0_0000);
		rq(OAG_K_NORMAL, OAG_M_INDEX, 4'h4, OAG_M_NONE, 4'h0, 16'h0000);
		chk("refused", {mode_err_r, src_mem_en_r}, 2'b10);
		req_valid = 1'b0;
	endtask
	task automatic t_ctrl();
		req_file_addr = 16'hbeef;
		rq(OAG_K_NORMAL, OAG_M_FILE, 4'h3, OAG_M_REG, 4'h5, 16'h0000);
		chk("file", {src_mem_en_r, src_ea_r}, 17'h1beef);
		chk("regdir", {dst_reg_en_r, dst_mem_en_r, dst_reg_idx_r}, 6'h25);
		rq(OAG_K_IMPLIED, OAG_M_FILE, 4'h9, OAG_M_IND, 4'h9, 16'h0000);
		chk("implied", {src_reg_en_r, src_reg_idx_r}, {1'b1, IMPLIED_REG});
		rq(OAG_K_TRANSFER, OAG_M_REG, 4'h4, OAG_M_FILE, 4'h0, 16'h0000);
		chk("src regdir", {src_reg_en_r, src_mem_en_r, src_reg_data_r}, {2'b10, 16'h0400});
		rq(OAG_K_JUMP, OAG_M_NONE, 4'h0, OAG_M_NONE, 4'h0, 16'h8000);
		chk("jump", {jump_valid_r, jump_target_r}, 25'h1ff8000);
		rq(OAG_K_HOLD, OAG_M_NONE, 4'h0, OAG_M_NONE, 4'h0, 16'hc003);
		chk("hold", {irq_hold_r, irq_hold_prio_r, hold_count_r}, {4'hf, 14'h0003});
		for (int i = 2; i >= 0; i--) begin
			rq(OAG_K_NOP, OAG_M_FILE, 4'h1, OAG_M_REG, 4'h2, 16'h7fff);
			chk("nop", {irq_hold_r, src_mem_en_r, dst_reg_en_r, hold_count_r}, {i > 0, 2'b00, 14'(i)});
		end
		req_valid = 1'b0;
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		chk("reset", {out_valid_r, src_mem_en_r, irq_hold_r, hold_count_r}, 32'h0);
		t_ptr();
		t_offset();
		t_ctrl();
		test_done();
	end
endmodule
